// File: rtl/stereo_decode_mono_blend.sv
// Stereo decoder with adaptive stereo-to-mono blend and an Avalon-MM register slave.
//
// Operation
// - Left is sum plus difference, right sum minus.
// - Pilot squared gives subcarrier phase reference.
// - Band-limited sum signal is the mono output.
// - Three metrics are evaluated side by side.
// - Poorest metric governs the blend amount.
// - Below mono threshold blends to full mono.
// - All above stereo thresholds keeps full stereo.
// - Between thresholds level proportional, rate limited.
// - Each metric has thresholds and rates programmable.
// - Status answer reports stereo or mono state.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module stereo_decode_mono_blend #(
  parameter int W = 16,   // Audio sample width.
  parameter int MW = 8    // Metric width.
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Avalon-MM register slave.
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Demodulated multiplex baseband, split into its parts.
  input wire logic sample_valid_i,
  input wire logic signed [W-1:0] sum_i,
  input wire logic signed [W-1:0] subcarrier_i,
  input wire logic signed [W-1:0] pilot_i,
  // Signal quality metrics.
  input wire logic [MW-1:0] strength_i,
  input wire logic [MW-1:0] noise_ratio_i,
  input wire logic [MW-1:0] multipath_i,
  // Audio outputs.
  output logic out_valid_o,
  output logic signed [W:0] left_o,
  output logic signed [W:0] right_o,
  output logic signed [W-1:0] mono_o,
  output logic stereo_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (W < 8 || W > 24) begin : g_bad_w
    $error("Audio width must lie between 8 and 24.");
  end
  if (MW != blend_pkg::FIELD_W) begin : g_bad_mw
    $error("Metric width must match the threshold field width.");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic stereo_en;                                      // Stereo allowed.
  logic [15:0] thr_reg [blend_pkg::NUM_METRICS];        // Mono and stereo thresholds.
  logic [15:0] rate_reg [blend_pkg::NUM_METRICS];       // Attack and release steps.
  logic [8:0] blend_level;                              // Governing blend factor.
  logic [1:0] gov_idx;                                  // Metric that governs.
  logic [31:0] status_word;                             // Status answer.
  logic [31:0] read_value;                              // Decoded read data.
  logic take_write;                                     // Write completes this edge.

  // A write completes at the edge where waitrequest is seen low.
  assign take_write = write_i && !waitrequest_o;

  // Assembles the signal quality status answer.
  always_comb begin
    status_word = '0;
    status_word[blend_pkg::STAT_LEVEL_LSB +: 9] = blend_level;
    status_word[blend_pkg::STAT_STEREO_BIT] = (blend_level == blend_pkg::LEVEL_FULL);
    status_word[blend_pkg::STAT_MONO_BIT] = (blend_level == blend_pkg::LEVEL_MONO);
    status_word[blend_pkg::STAT_GOV_LSB +: 2] = gov_idx;
  end

  // Decodes the read address; unmapped words read as zero.
  always_comb begin
    read_value = 32'h0000_0000;
    if (address_i == blend_pkg::CTRL_OFS) begin
      read_value[blend_pkg::CTRL_STEREO_EN_BIT] = stereo_en;
    end else if (address_i == blend_pkg::STATUS_OFS) begin
      read_value = status_word;
    end else begin
      for (int i = 0; i < blend_pkg::NUM_METRICS; i++) begin
        if (address_i == blend_pkg::THR_BASE_OFS + 8'(i) * blend_pkg::METRIC_STRIDE) begin
          read_value[15:0] = thr_reg[i];
        end else if (address_i == blend_pkg::RATE_BASE_OFS + 8'(i) * blend_pkg::METRIC_STRIDE) begin
          read_value[15:0] = rate_reg[i];
        end
      end
    end
  end

  // Holds waitrequest high except for the one answer cycle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0000_0000;
    end else if ((read_i || write_i) && waitrequest_o) begin
      // Answer one cycle after the request is seen.
      waitrequest_o <= 1'b0;
      readdata_o <= read_value;
    end else begin
      waitrequest_o <= 1'b1;
    end
  end

  // Stores the control word.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stereo_en <= blend_pkg::CTRL_RESET[blend_pkg::CTRL_STEREO_EN_BIT];
    end else if (take_write && address_i == blend_pkg::CTRL_OFS) begin
      stereo_en <= writedata_i[blend_pkg::CTRL_STEREO_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Per-metric blend trackers
  // ----------------------------------------------------------------
  logic [MW-1:0] quality [blend_pkg::NUM_METRICS];   // Quality, larger is better.
  logic [8:0] metric_level [blend_pkg::NUM_METRICS]; // Level each metric asks for.

  // Multipath grows as reception worsens, so it is inverted.
  assign quality[0] = strength_i;
  assign quality[1] = noise_ratio_i;
  assign quality[2] = ~multipath_i;

  for (genvar g = 0; g < blend_pkg::NUM_METRICS; g++) begin : g_metric
    // Stores this metric's thresholds and rates.
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        thr_reg[g] <= blend_pkg::THR_RESET;
        rate_reg[g] <= blend_pkg::RATE_RESET;
      end else if (take_write) begin
        if (address_i == blend_pkg::THR_BASE_OFS + 8'(g) * blend_pkg::METRIC_STRIDE) begin
          thr_reg[g] <= writedata_i[15:0];
        end else if (address_i == blend_pkg::RATE_BASE_OFS + 8'(g) * blend_pkg::METRIC_STRIDE) begin
          rate_reg[g] <= writedata_i[15:0];
        end
      end
    end

    // Tracks this metric's target at its own rates.
    metric_blend_track #(
      .MW(MW)
    ) u_track (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .step_i(sample_valid_i),
      .quality_i(quality[g]),
      .mono_thr_i(thr_reg[g][blend_pkg::THR_MONO_LSB +: MW]),
      .stereo_thr_i(thr_reg[g][blend_pkg::THR_STEREO_LSB +: MW]),
      .attack_i(rate_reg[g][blend_pkg::RATE_ATTACK_LSB +: 8]),
      .release_i(rate_reg[g][blend_pkg::RATE_RELEASE_LSB +: 8]),
      .level_o(metric_level[g])
    );
  end

  // ----------------------------------------------------------------
  // Governing level
  // ----------------------------------------------------------------
  logic [8:0] min_level;   // Lowest level of the three.
  logic [1:0] min_idx;     // Index of the lowest level.

  // Picks the metric that reports the poorest reception.
  always_comb begin
    min_level = metric_level[0];
    min_idx = blend_pkg::MET_STRENGTH;
    if (metric_level[1] < min_level) begin
      min_level = metric_level[1];
      min_idx = blend_pkg::MET_NOISE;
    end
    if (metric_level[2] < min_level) begin
      min_level = metric_level[2];
      min_idx = blend_pkg::MET_MULTIPATH;
    end
  end

  // Registers the governing level; a disabled stereo path forces mono.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      blend_level <= blend_pkg::LEVEL_FULL;
      gov_idx <= blend_pkg::MET_STRENGTH;
    end else begin
      blend_level <= stereo_en ? min_level : blend_pkg::LEVEL_MONO;
      gov_idx <= min_idx;
    end
  end

  // ----------------------------------------------------------------
  // Difference recovery
  // ----------------------------------------------------------------
  logic signed [2*W-1:0] pilot_sq;      // Pilot squared.
  logic signed [W-1:0] ref38;           // Doubled-phase reference.
  logic signed [2*W-1:0] demod;         // Subcarrier times reference.
  logic signed [W-1:0] diff_raw;        // Recovered difference before filtering.
  logic signed [W-1:0] diff_lp;         // Low-pass filtered difference.
  logic signed [W:0] diff_err;          // Filter input minus state.
  logic signed [W+9:0] diff_scaled;     // Difference times blend factor.
  logic signed [W-1:0] diff_blend;      // Difference after the blend.
  logic signed [W-1:0] sum_lp;          // Band-limited sum.
  logic signed [W:0] sum_err;           // Sum filter input minus state.

  // Squares the pilot: 2*p*p - 1 is the subcarrier cosine locked to it.
  always_comb begin
    pilot_sq = pilot_i * pilot_i;
    ref38 = W'((pilot_sq >>> (W - 2)) - (2*W)'(1 <<< (W - 1)));
    demod = subcarrier_i * ref38;
    diff_raw = W'(demod >>> (W - 2));
    diff_err = {diff_raw[W-1], diff_raw} - {diff_lp[W-1], diff_lp};
    sum_err = {sum_i[W-1], sum_i} - {sum_lp[W-1], sum_lp};
    diff_scaled = diff_lp * $signed({1'b0, blend_level});
    diff_blend = W'(diff_scaled >>> 8);
  end

  // One-pole low-pass filters on the sum and the recovered difference.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      diff_lp <= '0;
      sum_lp <= '0;
    end else if (sample_valid_i) begin
      diff_lp <= W'(diff_lp + W'(diff_err >>> 2));
      sum_lp <= W'(sum_lp + W'(sum_err >>> 1));
    end
  end

  // ----------------------------------------------------------------
  // Output matrix
  // ----------------------------------------------------------------
  logic sample_d;   // Filters have taken the sample.

  // Delays the strobe to line up with the filter states.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sample_d <= 1'b0;
    end else begin
      sample_d <= sample_valid_i;
    end
  end

  // Forms left and right from the sum and the blended difference.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      left_o <= '0;
      right_o <= '0;
      mono_o <= '0;
      stereo_o <= 1'b0;
    end else begin
      out_valid_o <= sample_d;
      stereo_o <= (blend_level == blend_pkg::LEVEL_FULL);
      if (sample_d) begin
        left_o <= {sum_lp[W-1], sum_lp} + {diff_blend[W-1], diff_blend};
        right_o <= {sum_lp[W-1], sum_lp} - {diff_blend[W-1], diff_blend};
        mono_o <= sum_lp;
      end
    end
  end

endmodule : stereo_decode_mono_blend

`default_nettype wire

// File: common/blend_pkg.sv
// Package with register map, field layout, reset values and widths of the stereo decoder and blender.
package blend_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;        // Control word.
  localparam logic [7:0] STATUS_OFS = 8'h04;      // Signal quality status answer.
  localparam logic [7:0] THR_BASE_OFS = 8'h10;    // Threshold word of metric 0.
  localparam logic [7:0] RATE_BASE_OFS = 8'h14;   // Rate word of metric 0.
  localparam logic [7:0] METRIC_STRIDE = 8'h08;   // Distance between metric register pairs.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_STEREO_EN_BIT = 0;   // 1 allows stereo, 0 forces mono.
  localparam int THR_STEREO_LSB = 0;       // Stereo threshold field, bits 7:0.
  localparam int THR_MONO_LSB = 8;         // Mono threshold field, bits 15:8.
  localparam int RATE_ATTACK_LSB = 0;      // Attack step field, bits 7:0.
  localparam int RATE_RELEASE_LSB = 8;     // Release step field, bits 15:8.
  localparam int STAT_LEVEL_LSB = 0;       // Blend level field, bits 8:0.
  localparam int STAT_STEREO_BIT = 16;     // Full stereo flag.
  localparam int STAT_MONO_BIT = 17;       // Full mono flag.
  localparam int STAT_GOV_LSB = 24;        // Governing metric index, bits 25:24.

  // ----------------------------------------------------------------
  // Widths, levels and reset values
  // ----------------------------------------------------------------
  localparam int NUM_METRICS = 3;          // Signal strength, noise ratio, multipath.
  localparam int FIELD_W = 8;              // Width of a threshold or rate field.
  localparam int LEVEL_W = 9;              // Width of the blend level.
  localparam logic [8:0] LEVEL_FULL = 9'h100;       // Level for full stereo.
  localparam logic [8:0] LEVEL_MONO = 9'h000;       // Level for full mono.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;  // Stereo allowed after reset.
  localparam logic [15:0] THR_RESET = 16'h1030;     // Mono 0x10, stereo 0x30.
  localparam logic [15:0] RATE_RESET = 16'h0104;    // Release 1, attack 4.

  // Metric indices.
  localparam logic [1:0] MET_STRENGTH = 2'h0;
  localparam logic [1:0] MET_NOISE = 2'h1;
  localparam logic [1:0] MET_MULTIPATH = 2'h2;

endpackage : blend_pkg

// File: rtl/metric_blend_track.sv
// One metric's blend target and its rate-limited blend level.
`timescale 1ns/1ps
`default_nettype none

module metric_blend_track #(
  parameter int MW = 8
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Sample strobe.
  input wire logic step_i,
  // Quality value, larger is better.
  input wire logic [MW-1:0] quality_i,
  // Programmed thresholds and rates.
  input wire logic [MW-1:0] mono_thr_i,
  input wire logic [MW-1:0] stereo_thr_i,
  input wire logic [7:0] attack_i,
  input wire logic [7:0] release_i,
  // Current blend level, 0 mono up to full stereo.
  output logic [8:0] level_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MW < 1 || MW > 16) begin : g_bad_mw
    $error("Metric width must lie between 1 and 16.");
  end

  // ----------------------------------------------------------------
  // Target level
  // ----------------------------------------------------------------
  logic [8:0] target;             // Level the metric asks for.
  logic [MW+7:0] span_num;        // Distance above mono threshold, scaled.
  logic [MW-1:0] span_den;        // Distance between the two thresholds.
  logic [MW+7:0] ratio;           // Proportional level before sizing.

  // Maps the quality onto a level between the two thresholds.
  always_comb begin
    span_num = {quality_i - mono_thr_i, 8'h00};
    span_den = stereo_thr_i - mono_thr_i;
    ratio = '0;
    if (quality_i < mono_thr_i) begin
      target = blend_pkg::LEVEL_MONO;
    end else if (quality_i >= stereo_thr_i) begin
      target = blend_pkg::LEVEL_FULL;
    end else begin
      // Divisor is non-zero here because stereo lies above mono.
      ratio = span_num / (MW+8)'(span_den);
      target = ratio[8:0];
    end
  end

  // ----------------------------------------------------------------
  // Rate-limited level
  // ----------------------------------------------------------------
  logic [9:0] down_room;   // Level minus attack step.
  logic [9:0] up_room;     // Level plus release step.

  // Computes the next candidate levels with one spare bit.
  always_comb begin
    down_room = {1'b0, level_o} - {2'b00, attack_i};
    up_room = {1'b0, level_o} + {2'b00, release_i};
  end

  // Moves the level toward the target once per sample.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level_o <= blend_pkg::LEVEL_FULL;
    end else if (step_i) begin
      if (target < level_o) begin
        // Toward mono uses the attack step, never overshooting.
        if (down_room[9] || down_room[8:0] < target) begin
          level_o <= target;
        end else begin
          level_o <= down_room[8:0];
        end
      end else if (target > level_o) begin
        // Toward stereo uses the release step, never overshooting.
        if (up_room > {1'b0, target}) begin
          level_o <= target;
        end else begin
          level_o <= up_room[8:0];
        end
      end
    end
  end

endmodule : metric_blend_track

`default_nettype wire

// File: tb/blend_monitor.sv
// Checker for the bus handshake and audio timing of the stereo blender.
`timescale 1ns/1ps
`default_nettype none
module blend_checker #(
  parameter int W = 16
) (
  // Clock, reset and bus.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  // Audio stream.
  input wire logic sample_valid_i,
  input wire logic out_valid_o,
  input wire logic signed [W:0] left_o,
  input wire logic signed [W:0] right_o,
  input wire logic signed [W-1:0] mono_o,
  input wire logic stereo_o
);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic rd_go;  // A read that the slave takes now.
  assign rd_go = read_i && waitrequest_o;
  a_ack_next: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("request not answered in one cycle");
  a_ack_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("answer stood longer than one cycle");
  a_idle_wait: assert property (!read_i && !write_i |-> waitrequest_o)
    else $error("answer without a request");
  a_valid_delay: assert property (sample_valid_i |-> ##2 out_valid_o)
    else $error("output sample missing");
  a_valid_cause: assert property (out_valid_o |-> $past(sample_valid_i, 2))
    else $error("output sample without input");
  a_outputs_hold: assert property (!out_valid_o |-> $stable(left_o) && $stable(right_o))
    else $error("audio changed between samples");
  a_mix_symmetry: assert property (out_valid_o |->
    {left_o[W], left_o} + {right_o[W], right_o} == {mono_o[W-1], mono_o, 1'b0})
    else $error("left plus right differs from twice mono");
  a_status_flags: assert property (rd_go && address_i == blend_pkg::STATUS_OFS |=>
    readdata_o[16] == (readdata_o[8:0] == 9'h100) && readdata_o[17] == (readdata_o[8:0] == 9'h000))
    else $error("status flags disagree with level");
  a_unmapped_zero: assert property (rd_go && address_i == 8'h08 |=> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  c_sample: cover property (out_valid_o && stereo_o);
  c_mono: cover property ($fell(stereo_o));
  c_write: cover property (write_i && !waitrequest_o);
endmodule : blend_checker
bind stereo_decode_mono_blend blend_checker #(.W(W)) u_check (.clock_i(clock_i), .rst_i(rst_i),
  .address_i(address_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .sample_valid_i(sample_valid_i), .out_valid_o(out_valid_o),
  .left_o(left_o), .right_o(right_o), .mono_o(mono_o), .stereo_o(stereo_o));
`default_nettype wire

// File: tb/test_stereo_decode_mono_blend.sv
// Self-checking bench for the stereo decoder and blender.
`timescale 1ns/1ps
`default_nettype none
module test_stereo_decode_mono_blend;
  // ------------------------------------------------
  // Stimulus, outputs and bookkeeping
  // ------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic sample_valid_i = 1'b0;
  logic signed [15:0] sum_i = 16'sh0;
  logic signed [15:0] subcarrier_i = 16'sh0;
  logic signed [15:0] pilot_i = 16'sh0;
  logic [7:0] strength_i = 8'hff;
  logic [7:0] noise_ratio_i = 8'hff;
  logic [7:0] multipath_i = 8'h00;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic out_valid_o;
  logic signed [16:0] left_o;
  logic signed [16:0] right_o;
  logic signed [15:0] mono_o;
  logic stereo_o;
  longint sum_lp = 0;   // Model of the sum low-pass.
  longint diff_lp = 0;  // Model of the difference low-pass.
  int bad_count = 0;
  int num_checks = 0;
  logic [31:0] rd;
  localparam logic [31:0] SMASK = 32'h0303_01ff;  // Status fields under test.

  // The clock toggles every half period of 5 ns.
  always #5 clock_i = ~clock_i;

  stereo_decode_mono_blend #(.W(16), .MW(8)) DUT (.clock_i(clock_i), .rst_i(rst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sample_valid_i(sample_valid_i),
    .sum_i(sum_i), .subcarrier_i(subcarrier_i), .pilot_i(pilot_i), .strength_i(strength_i),
    .noise_ratio_i(noise_ratio_i), .multipath_i(multipath_i), .out_valid_o(out_valid_o),
    .left_o(left_o), .right_o(right_o), .mono_o(mono_o), .stereo_o(stereo_o));

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  // Prints the verdict and stops.
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer held until waitrequest is sampled low.
  task automatic bus_xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clock_i);
    address_i <= adr;
    writedata_i <= wd;
    write_i <= wr;
    read_i <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_i);
      if (waitrequest_o === 1'b0) break;
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (n == 20) begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask : bus_xfer

  // Reads a word and compares the masked fields.
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
    bus_xfer(1'b0, adr, 32'h0);
    check(rd & msk, exp);
  endtask : rd_chk

  // Sends one sample, steps the model and optionally checks the outputs.
  task automatic sample(input logic signed [15:0] s, input logic signed [15:0] c,
                        input logic signed [15:0] p, input bit chk, input longint lvl);
    longint ref_v;
    longint blend;
    int n;
    @(posedge clock_i);
    sample_valid_i <= 1'b1;
    sum_i <= s;
    subcarrier_i <= c;
    pilot_i <= p;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    ref_v = ((longint'(p) * p) >>> 14) - 32768;
    diff_lp += (((longint'(c) * ref_v) >>> 14) - diff_lp) >>> 2;
    sum_lp += (s - sum_lp) >>> 1;
    blend = (diff_lp * lvl) >>> 8;
    for (n = 0; n < 8; n++) begin
      @(posedge clock_i);
      if (out_valid_o === 1'b1) break;
    end
    if (n == 8) begin
      check(32'h0, 32'h1);
      complete_run();
    end
    if (chk) begin
      check(left_o, 17'(sum_lp + blend));
      check(right_o, 17'(sum_lp - blend));
      check(mono_o, 16'(sum_lp));
    end
  endtask : sample

  // Sets the three quality inputs.
  task automatic metrics(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clock_i);
    strength_i <= a;
    noise_ratio_i <= b;
    multipath_i <= c;
  endtask : metrics

  // Holds reset for six cycles and clears the model.
  task automatic do_reset;
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    sum_lp = 0;
    diff_lp = 0;
  endtask : do_reset

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  // Reset values, fast rates with read back, two unmapped words.
  task automatic t_regs;
    rd_chk(blend_pkg::CTRL_OFS, blend_pkg::CTRL_RESET, '1);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0001_0100, 32'h0003_01ff);
    for (int m = 0; m < 3; m++) begin
      rd_chk(blend_pkg::THR_BASE_OFS + 8'(m) * blend_pkg::METRIC_STRIDE, 32'(blend_pkg::THR_RESET), '1);
      rd_chk(blend_pkg::RATE_BASE_OFS + 8'(m) * blend_pkg::METRIC_STRIDE, 32'(blend_pkg::RATE_RESET), '1);
      bus_xfer(1'b1, blend_pkg::RATE_BASE_OFS + 8'(m) * blend_pkg::METRIC_STRIDE, 32'hffff);
      rd_chk(blend_pkg::RATE_BASE_OFS + 8'(m) * blend_pkg::METRIC_STRIDE, 32'hffff, '1);
    end
    bus_xfer(1'b1, 8'h0c, 32'hffff_ffff);
    rd_chk(8'h0c, 32'h0, '1);
    rd_chk(8'h08, 32'h0, '1);
  endtask : t_regs

  // Good reception: full stereo audio through the pilot reference.
  task automatic t_stereo;
    logic signed [15:0] pil [4] = '{16'sh7fff, 16'sh0000, 16'sh4000, -16'sh6000};
    for (int i = 0; i < 4; i++) begin
      sample(16'sh0400 - 16'(i * 300), 16'sh0800 + 16'(i * 64), pil[i], 1'b1, 256);
      check(stereo_o, 1'b1);
    end
  endtask : t_stereo

  // Each metric alone below its mono threshold forces mono and governs.
  task automatic t_mono;
    for (int m = 0; m < 3; m++) begin
      metrics(m == 0 ? 8'h00 : 8'hff, m == 1 ? 8'h00 : 8'hff, m == 2 ? 8'hff : 8'h00);
      repeat (3) sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
      sample(16'sh0180, -16'sh0300, 16'sh7fff, 1'b1, 0);
      check(stereo_o, 1'b0);
      rd_chk(blend_pkg::STATUS_OFS, 32'h0002_0000 | (32'(m) << 24), SMASK);
      metrics(8'hff, 8'hff, 8'h00);
      repeat (3) sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
      rd_chk(blend_pkg::STATUS_OFS, 32'h0001_0100, 32'h0003_01ff);
    end
  endtask : t_mono

  // Levels between thresholds, stepped at attack and release rates.
  task automatic t_prop;
    bus_xfer(1'b1, blend_pkg::RATE_BASE_OFS, 32'h0404);
    metrics(8'h20, 8'hff, 8'h00);
    sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0000_00fc, SMASK);
    repeat (40) sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0000_0080, SMASK);
    metrics(8'h20, 8'h18, 8'h00);
    sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0100_0040, SMASK);
    metrics(8'hff, 8'hff, 8'h00);
    sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0000_0084, SMASK);
    bus_xfer(1'b1, blend_pkg::RATE_BASE_OFS, 32'hffff);
    repeat (2) sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
  endtask : t_prop

  // Stereo disabled by control: mono audio and status.
  task automatic t_forced;
    bus_xfer(1'b1, blend_pkg::CTRL_OFS, 32'h0);
    rd_chk(blend_pkg::CTRL_OFS, 32'h0, '1);
    sample(16'sh0300, 16'sh0600, 16'sh7fff, 1'b0, 0);
    sample(-16'sh0200, 16'sh0700, 16'sh7fff, 1'b1, 0);
    check(stereo_o, 1'b0);
    rd_chk(blend_pkg::STATUS_OFS, 32'h0002_0000, 32'h0003_01ff);
    bus_xfer(1'b1, blend_pkg::CTRL_OFS, 32'h1);
    repeat (2) sample(16'sh0100, 16'sh0200, 16'sh7fff, 1'b0, 0);
    check(stereo_o, 1'b1);
  endtask : t_forced

  // Main sequence, with a second reset in mid-run.
  initial begin
    do_reset();
    t_regs();
    t_stereo();
    t_mono();
    t_prop();
    t_forced();
    do_reset();
    t_regs();
    complete_run();
  end
endmodule : test_stereo_decode_mono_blend
`default_nettype wire
